// ### hw/dma_xfer_engine.sv
// DMA transfer engine: counter, termination causes and strobe pins
`timescale 1ns/1ps
module dma_xfer_engine (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_cmd_wr,
   input wire logic [7:0] i_cmd,
   input wire logic i_cnt_load,
   input wire logic [31:0] i_cnt_value,
   input wire logic i_cnt_disable,
   input wire logic i_ide_sel,
   input wire logic i_master,
   input wire logic [1:0] i_strobe_mode,
   input wire logic i_eot_sync,
   input wire logic i_ready_sync,
   input wire logic i_dreq_sync,
   input wire logic i_strb_sync,
   input wire logic i_short_out,
   input wire logic [15:0] i_wdata,
   output ep_dma_pkg::dma_ctl_t o_ctl,
   output ep_dma_pkg::dma_bus_t o_bus,
   output logic [31:0] o_count,
   output logic o_busy,
   output logic o_done_pulse,
   output logic o_ext_end_pulse,
   output logic o_int_end_pulse,
   output logic o_data_pulse
);
   import ep_dma_pkg::*;

   dma_mode_t mode_q, mode_d;
   logic [31:0] count_q;
   logic [3:0] tmr_q;
   logic strb_q;
   logic strb_prev_q;
   logic bus_en_q;
   logic [15:0] dout_q;
   logic started_q;

   // Command decode
   wire is_gslave_cmd = i_cmd_wr && (i_cmd == CMD_GENERIC_SLAVE_TRANSFER_RD || i_cmd == CMD_GENERIC_SLAVE_TRANSFER_WR) && !i_ide_sel && !i_master;
   wire is_master_cmd = i_cmd_wr && (i_cmd == CMD_MDMA_RD || i_cmd == CMD_MDMA_WR);
   wire is_pio_cmd = i_cmd_wr && (i_cmd == CMD_PIO_RD || i_cmd == CMD_PIO_WR);
   wire is_udma_cmd = i_cmd_wr && (i_cmd == CMD_UDMA_RD || i_cmd == CMD_UDMA_WR);
   wire abort_cmd = i_cmd_wr && (i_cmd == CMD_RESET_DMA || (i_cmd == CMD_MDMA_STOP && mode_q == DMA_MASTER));
   wire counting = (mode_q != DMA_IDLE) && !(mode_q == DMA_GSLAVE && i_cnt_disable);
   // Slave strobe edge from the external controller
   wire slave_beat = (mode_q == DMA_GSLAVE) && i_strb_sync && !strb_prev_q;
   // Own strobe completes when timer expires and ready is high
   wire own_beat = (mode_q inside {DMA_MASTER, DMA_PIO, DMA_UDMA}) && strb_q && tmr_q == '0 && i_ready_sync;
   wire beat = slave_beat || own_beat;
   wire at_zero = counting && beat && count_q == 32'h1;
   wire ext_end = (mode_q == DMA_GSLAVE) && i_eot_sync;
   wire int_end = (mode_q == DMA_GSLAVE) && i_cnt_disable && i_short_out;

   // Next mode
   always_comb begin
      mode_d = mode_q;
      if (abort_cmd || at_zero || ext_end || int_end) begin
         mode_d = DMA_IDLE;
      end else if (is_gslave_cmd) begin
         mode_d = DMA_GSLAVE;
      end else if (is_master_cmd) begin
         mode_d = DMA_MASTER;
      end else if (is_pio_cmd) begin
         mode_d = DMA_PIO;
      end else if (is_udma_cmd) begin
         mode_d = DMA_UDMA;
      end
   end

   // Mode, counter and started flag
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_q <= DMA_IDLE;
         count_q <= '0;
         started_q <= 1'b0;
         strb_prev_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         strb_prev_q <= i_strb_sync;
         if (i_cnt_load) begin
            count_q <= i_cnt_value;
         end else if (counting && beat) begin
            count_q <= count_q - 32'h1;
         end
         if (mode_d != DMA_IDLE) begin
            started_q <= 1'b1;
         end else if (i_cmd_wr && i_cmd == CMD_RESET_DMA) begin
            started_q <= 1'b0;
         end
      end
   end

   // Own strobe generator: assert, hold a fixed time, wait for ready
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         strb_q <= 1'b0;
         tmr_q <= '0;
         bus_en_q <= 1'b0;
         dout_q <= '0;
      end else begin
         bus_en_q <= started_q;
         dout_q <= i_wdata;
         if (mode_d inside {DMA_MASTER, DMA_PIO, DMA_UDMA} && !strb_q && (mode_q != DMA_MASTER || i_dreq_sync)) begin
            strb_q <= 1'b1;
            tmr_q <= STROBE_CYC;
         end else if (own_beat || mode_d == DMA_IDLE) begin
            strb_q <= 1'b0;
         end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - 4'h1;
         end
      end
   end

   // Pins: strobes chosen by mode field; UDMA reuses ack and read strobe
   always_comb begin
      o_ctl.dreq = (mode_q == DMA_GSLAVE);
      o_ctl.dack = strb_q && (mode_q != DMA_PIO) && (i_strobe_mode != 2'h1 || mode_q == DMA_UDMA);
      o_ctl.dior = strb_q && (mode_q != DMA_MASTER || i_strobe_mode != 2'h0);
      o_ctl.diow = (mode_q == DMA_UDMA) ? 1'b0 : strb_q && (mode_q != DMA_MASTER || i_strobe_mode != 2'h0);
   end
   assign o_bus.data_o = dout_q;
   assign o_bus.data_oe = bus_en_q;
   assign o_count = count_q;
   assign o_busy = (mode_q != DMA_IDLE);
   assign o_done_pulse = at_zero;
   assign o_ext_end_pulse = ext_end;
   assign o_int_end_pulse = int_end;
   assign o_data_pulse = beat;
endmodule

// ### hw/ep_buffer_dma_ctrl.sv
// Top: endpoint buffer configuration registers, Wishbone slave and DMA control
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
module ep_buffer_dma_ctrl (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_bus_reset,
   input wire logic i_cyc,
   input wire logic i_stb,
   input wire logic i_we,
   input wire logic [7:0] i_adr,
   input wire logic [3:0] i_sel,
   input wire logic [31:0] i_dat,
   output logic [31:0] o_dat,
   output logic o_ack,
   input wire ep_dma_pkg::usb_evt_t i_usb,
   input wire logic i_pio_byte_wr,
   input wire logic i_bus16,
   input wire logic i_eot_pin,
   input wire logic i_ready_pin,
   input wire logic i_dreq_pin,
   input wire logic i_strb_pin,
   input wire logic [15:0] i_dma_data,
   output ep_dma_pkg::dma_ctl_t o_dma_ctl,
   output ep_dma_pkg::dma_bus_t o_dma_bus,
   output logic o_validate,
   output logic [ep_dma_pkg::SLOT_W-1:0] o_validate_slot,
   output logic o_send_empty,
   output logic [ep_dma_pkg::EP_SLOTS-1:0] o_toggle_reset,
   output logic [ep_dma_pkg::EP_SLOTS-1:0] o_ep_enable,
   output logic [ep_dma_pkg::EP_SLOTS-1:0] o_dbl_buf,
   output logic [1:0] o_transactions_per_microframe,
   output logic o_odd_lane_low,
   output logic o_dma_irq
);
   import ep_dma_pkg::*;

   // Register storage
   logic [15:0] pkt_size_q;
   logic [15:0] len_q [EP_SLOTS];
   logic [15:0] type_q [EP_SLOTS];
   logic [15:0] wcount_q [EP_SLOTS];
   logic [EP_SEL_W-1:0] endpoint_selector_q;
   logic dir_q;
   logic [15:0] cfg_q;
   logic [31:0] cnt_stage_q;
   logic transfer_complete_flag_q;
   logic external_end_flag_q;
   logic internal_end_flag_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic validate_q;
   logic [SLOT_W-1:0] validate_slot_q;
   logic empty_q;
   logic [EP_SLOTS-1:0] toggle_rst_q;
   logic [2:0] eot_s_q, rdy_s_q, dreq_s_q, strb_s_q;
   logic [1:0] eot_ff_q, rdy_ff_q, dreq_ff_q, strb_ff_q;

   // Engine outputs
   logic [31:0] count;
   logic busy;
   logic done_p;
   logic ext_p;
   logic int_p;
   logic data_p;

   // Bus decode
   wire req = i_cyc && i_stb && !ack_q;
   wire wr = req && i_we;
   wire [SLOT_W-1:0] cur = slot_of(endpoint_selector_q, dir_q);
   wire ep0_sel = (endpoint_selector_q == '0);
   wire [31:0] wmask = {{8{i_sel[3]}}, {8{i_sel[2]}}, {8{i_sel[1]}}, {8{i_sel[0]}}};
   wire wr_size = wr && i_adr == ADDR_PKT_SIZE;
   wire wr_type = wr && i_adr == ADDR_EP_TYPE;
   wire wr_len = wr && i_adr == ADDR_PKT_LEN;
   wire wr_idx = wr && i_adr == ADDR_EP_INDEX;
   wire wr_cmd = wr && i_adr == ADDR_DMA_CMD && i_sel[0];
   wire wr_cfg = wr && i_adr == ADDR_DMA_CFG;
   wire wr_cnt = wr && i_adr == ADDR_XFER_CNT;
   wire wr_stat = wr && i_adr == ADDR_DMA_STAT;
   wire cnt_load = wr_cnt && i_sel[3];
   wire [31:0] cnt_new = (cnt_stage_q & ~wmask) | (i_dat & wmask);
   wire [10:0] fifo_size_bytes = pkt_size_q[FIFO_SIZE_MSB:0];
   wire [1:0] transactions_per_microframe = pkt_size_q[TRANSACTIONS_PER_MICROFRAME_MSB:TRANSACTIONS_PER_MICROFRAME_LSB];
   wire [1:0] endpoint_transfer_type = type_q[cur][1:0];
   wire suppress_empty_packet = type_q[cur][NOEMPTY_BIT];
   wire [15:0] pio_step = i_bus16 ? 16'h2 : 16'h1;
   wire [15:0] wcount_next = wcount_q[cur] + pio_step;

   // Level synchronisers; first stage is read only by the second
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         eot_ff_q <= '0;
         rdy_ff_q <= '0;
         dreq_ff_q <= '0;
         strb_ff_q <= '0;
      end else begin
         eot_ff_q <= {eot_ff_q[0], i_eot_pin};
         rdy_ff_q <= {rdy_ff_q[0], i_ready_pin};
         dreq_ff_q <= {dreq_ff_q[0], i_dreq_pin};
         strb_ff_q <= {strb_ff_q[0], i_strb_pin};
      end
   end
   assign eot_s_q = {1'b0, eot_ff_q};
   assign rdy_s_q = {1'b0, rdy_ff_q};
   assign dreq_s_q = {1'b0, dreq_ff_q};
   assign strb_s_q = {1'b0, strb_ff_q};

   // Global registers: size, index, DMA config, staged count, DMA flags
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         pkt_size_q <= '0;
         endpoint_selector_q <= '0;
         dir_q <= 1'b0;
         cfg_q <= '0;
         cnt_stage_q <= '0;
         transfer_complete_flag_q <= 1'b0;
         external_end_flag_q <= 1'b0;
         internal_end_flag_q <= 1'b0;
      end else begin
         if (wr_size && !ep0_sel) begin
            pkt_size_q <= ((pkt_size_q & ~wmask[15:0]) | (i_dat[15:0] & wmask[15:0])) & PKT_SIZE_MASK;
         end
         if (wr_idx && i_sel[0]) begin
            endpoint_selector_q <= i_dat[EP_SEL_W:1];
            dir_q <= i_dat[0];
         end
         if (wr_cfg) begin
            cfg_q <= ((cfg_q & ~wmask[15:0]) | (i_dat[15:0] & wmask[15:0])) & DMA_CFG_MASK;
         end
         if (wr_cnt) begin
            cnt_stage_q <= cnt_new;
         end
         // Set wins over a write-one clear
         transfer_complete_flag_q <= done_p | (transfer_complete_flag_q & ~(wr_stat & i_dat[0]));
         external_end_flag_q <= ext_p | (external_end_flag_q & ~(wr_stat & i_dat[1]));
         internal_end_flag_q <= int_p | (internal_end_flag_q & ~(wr_stat & i_dat[2]));
      end
   end

   // Per-endpoint type, length and PIO byte count
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < EP_SLOTS; i++) begin
            len_q[i] <= LEN_RESET;
            type_q[i] <= '0;
            wcount_q[i] <= '0;
         end
         toggle_rst_q <= '0;
         validate_q <= 1'b0;
         validate_slot_q <= '0;
      end else begin
         toggle_rst_q <= '0;
         validate_q <= 1'b0;
         for (int i = 0; i < EP_SLOTS; i++) begin
            if (i_bus_reset) begin
               len_q[i] <= LEN_RESET;
            end else if (wr_size && !ep0_sel) begin
               len_q[i] <= {5'h0, i_dat[FIFO_SIZE_MSB:0]};
            end else if (i_usb.out_ack && i_usb.slot == SLOT_W'(i)) begin
               len_q[i] <= i_usb.out_bytes;
            end else if (wr_len && cur == SLOT_W'(i)) begin
               len_q[i] <= (len_q[i] & ~wmask[15:0]) | (i_dat[15:0] & wmask[15:0]);
            end
         end
         if (wr_type) begin
            type_q[cur] <= ((type_q[cur] & ~wmask[15:0]) | (i_dat[15:0] & wmask[15:0])) & EP_TYPE_MASK;
            // Enable rising after being cleared resets the toggle
            toggle_rst_q[cur] <= i_sel[0] && i_dat[ENABLE_BIT] && !type_q[cur][ENABLE_BIT];
         end
         // Processor IN writes: validate once count meets length
         if (i_pio_byte_wr && dir_q && !busy) begin
            if (wcount_next >= len_q[cur] && len_q[cur] != '0) begin
               wcount_q[cur] <= '0;
               validate_q <= 1'b1;
               validate_slot_q <= cur;
            end else begin
               wcount_q[cur] <= wcount_next;
            end
         end
      end
   end

   // Empty packet on IN token in DMA mode
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         empty_q <= 1'b0;
      end else begin
         empty_q <= i_usb.in_token && busy && !type_q[i_usb.slot][NOEMPTY_BIT]
                    && (len_q[i_usb.slot] == '0 || fifo_size_bytes == '0);
      end
   end

   // Wishbone slave: one wait state, read data registered
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= req;
         unique case (i_adr)
            ADDR_PKT_SIZE: rdata_q <= {16'h0, pkt_size_q};
            ADDR_EP_TYPE: rdata_q <= {16'h0, type_q[cur]};
            ADDR_PKT_LEN: rdata_q <= {16'h0, len_q[cur]};
            ADDR_EP_INDEX: rdata_q <= {27'h0, endpoint_selector_q, dir_q};
            ADDR_DMA_CMD: rdata_q <= CMD_READBACK;
            ADDR_XFER_CNT: rdata_q <= count;
            ADDR_DMA_CFG: rdata_q <= {16'h0, cfg_q};
            ADDR_DMA_STAT: rdata_q <= {28'h0, busy, internal_end_flag_q, external_end_flag_q,
                                       transfer_complete_flag_q};
            ADDR_EP_STAT: rdata_q <= {16'h0, wcount_q[cur]};
            default: rdata_q <= '0;
         endcase
      end
   end

   // Transfer engine
   dma_xfer_engine u_engine (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_cmd_wr(wr_cmd),
      .i_cmd(i_dat[7:0]),
      .i_cnt_load(cnt_load),
      .i_cnt_value(cnt_new),
      .i_cnt_disable(cfg_q[CFG_CNTDIS_BIT]),
      .i_ide_sel(cfg_q[CFG_IDE_BIT]),
      .i_master(cfg_q[CFG_MASTER_BIT]),
      .i_strobe_mode(cfg_q[CFG_MODE_MSB:CFG_MODE_LSB]),
      .i_eot_sync(eot_s_q[1]),
      .i_ready_sync(rdy_s_q[1]),
      .i_dreq_sync(dreq_s_q[1]),
      .i_strb_sync(strb_s_q[1]),
      .i_short_out(i_usb.short_out),
      .i_wdata(i_dma_data),
      .o_ctl(o_dma_ctl),
      .o_bus(o_dma_bus),
      .o_count(count),
      .o_busy(busy),
      .o_done_pulse(done_p),
      .o_ext_end_pulse(ext_p),
      .o_int_end_pulse(int_p),
      .o_data_pulse(data_p)
   );

   // Outputs
   assign o_dat = rdata_q;
   assign o_ack = ack_q;
   assign o_validate = validate_q;
   assign o_validate_slot = validate_slot_q;
   assign o_send_empty = empty_q;
   assign o_toggle_reset = toggle_rst_q;
   assign o_transactions_per_microframe = (transactions_per_microframe == TRANSACTIONS_PER_MICROFRAME_RESERVED) ? 2'h0 : transactions_per_microframe;
   // Odd final byte goes on the lower lane of a 16-bit bus
   assign o_odd_lane_low = i_bus16 && len_q[cur][0];
   assign o_dma_irq = transfer_complete_flag_q | external_end_flag_q | internal_end_flag_q;
   always_comb begin
      for (int i = 0; i < EP_SLOTS; i++) begin
         o_ep_enable[i] = type_q[i][ENABLE_BIT];
         o_dbl_buf[i] = type_q[i][DOUBLE_BUFFER_ENABLE_BIT];
      end
   end
endmodule

// ### hw/ep_dma_pkg.sv
// Package: register map, field layouts, commands and carriers for the endpoint buffer and DMA control block
package ep_dma_pkg;
   localparam int NUM_EP = 8;
   localparam int EP_SEL_W = 4;
   localparam int EP_SLOTS = 2 * NUM_EP;
   localparam int SLOT_W = 4;
   // Byte offsets on the bus
   localparam logic [7:0] ADDR_PKT_SIZE = 8'h04;
   localparam logic [7:0] ADDR_EP_TYPE = 8'h08;
   localparam logic [7:0] ADDR_PKT_LEN = 8'h1C;
   localparam logic [7:0] ADDR_EP_INDEX = 8'h2C;
   localparam logic [7:0] ADDR_DMA_CMD = 8'h30;
   localparam logic [7:0] ADDR_XFER_CNT = 8'h34;
   localparam logic [7:0] ADDR_DMA_CFG = 8'h38;
   localparam logic [7:0] ADDR_DMA_STAT = 8'h40;
   localparam logic [7:0] ADDR_EP_STAT = 8'h44;
   // Field positions
   localparam int FIFO_SIZE_MSB = 10;
   localparam int TRANSACTIONS_PER_MICROFRAME_LSB = 11;
   localparam int TRANSACTIONS_PER_MICROFRAME_MSB = 12;
   localparam int DOUBLE_BUFFER_ENABLE_BIT = 2;
   localparam int ENABLE_BIT = 3;
   localparam int NOEMPTY_BIT = 4;
   localparam int CFG_MODE_LSB = 2;
   localparam int CFG_MODE_MSB = 3;
   localparam int CFG_CNTDIS_BIT = 7;
   localparam int CFG_IDE_BIT = 13;
   localparam int CFG_MASTER_BIT = 15;
   localparam logic [15:0] PKT_SIZE_MASK = 16'h1FFF;
   localparam logic [15:0] EP_TYPE_MASK = 16'h001F;
   localparam logic [15:0] DMA_CFG_MASK = 16'hA08C;
   localparam logic [15:0] LEN_RESET = 16'h0000;
   localparam logic [31:0] CMD_READBACK = 32'h000000FF;
   localparam logic [1:0] TRANSACTIONS_PER_MICROFRAME_RESERVED = 2'h3;
   // Endpoint transfer types
   localparam logic [1:0] TYPE_ISO = 2'h1;
   localparam logic [1:0] TYPE_BULK = 2'h2;
   localparam logic [1:0] TYPE_INTR = 2'h3;
   // DMA commands
   localparam logic [7:0] CMD_GENERIC_SLAVE_TRANSFER_RD = 8'h00;
   localparam logic [7:0] CMD_GENERIC_SLAVE_TRANSFER_WR = 8'h01;
   localparam logic [7:0] CMD_UDMA_RD = 8'h02;
   localparam logic [7:0] CMD_UDMA_WR = 8'h03;
   localparam logic [7:0] CMD_PIO_RD = 8'h04;
   localparam logic [7:0] CMD_PIO_WR = 8'h05;
   localparam logic [7:0] CMD_MDMA_RD = 8'h06;
   localparam logic [7:0] CMD_MDMA_WR = 8'h07;
   localparam logic [7:0] CMD_RESET_DMA = 8'h11;
   localparam logic [7:0] CMD_MDMA_STOP = 8'h12;
   // Strobe timing in ns and cycles
   localparam int CLK_NS = 20;
   localparam int STROBE_NS = 70;
   localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);

   typedef enum {DMA_IDLE, DMA_GSLAVE, DMA_MASTER, DMA_PIO, DMA_UDMA} dma_mode_t;

   // Pins of the DMA side; the data bus is split in/out/enable
   typedef struct packed {
      logic dreq;
      logic dack;
      logic diow;
      logic dior;
   } dma_ctl_t;
   typedef struct packed {
      logic [15:0] data_o;
      logic data_oe;
   } dma_bus_t;

   // Per-endpoint events from the USB engine
   typedef struct packed {
      logic out_ack;
      logic [15:0] out_bytes;
      logic in_token;
      logic short_out;
      logic [SLOT_W-1:0] slot;
   } usb_evt_t;

   // 4-bit slot index: {low 3 bits of endpoint, direction}
   function automatic logic [SLOT_W-1:0] slot_of(input logic [EP_SEL_W-1:0] ep, input logic dir);
      return SLOT_W'({ep[EP_SEL_W-2:0], dir});
   endfunction
endpackage

// ### verif/dma_far_model.sv
// Far-side DMA controller model: strobes, request, end of transfer, data
`timescale 1ns/1ps
module dma_far_model (
   input wire logic i_core_clk,
   input wire logic i_go,
   input wire logic i_end,
   output logic o_strb,
   output logic o_eot,
   output logic o_ready,
   output logic o_dreq,
   output logic [15:0] o_data
);
   logic [7:0] cnt_q = 8'h00;
   logic [15:0] data_q = 16'hA5A5;
   // Strobe phase counter; data never holds still, only the DUT's dout_q register latches it
   always_ff @(posedge i_core_clk) begin
      cnt_q <= i_go ? cnt_q + 8'h01 : 8'h00;
      data_q <= ~data_q;
   end
   assign o_strb = cnt_q[2];
   assign o_eot = i_end;
   assign o_ready = 1'b1;
   assign o_dreq = i_go;
   assign o_data = data_q;
endmodule

// ### verif/ep_dma_props.sv
// Checker for the endpoint buffer and DMA control block
`timescale 1ns/1ps
module ep_dma_props
   import ep_dma_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_cyc,
   input wire logic i_stb,
   input wire logic i_we,
   input wire logic [7:0] i_adr,
   input wire logic [31:0] o_dat,
   input wire logic o_ack,
   input wire ep_dma_pkg::usb_evt_t i_usb,
   input wire logic i_pio_byte_wr,
   input wire ep_dma_pkg::dma_bus_t o_dma_bus,
   input wire logic o_validate,
   input wire logic o_send_empty,
   input wire logic [ep_dma_pkg::EP_SLOTS-1:0] o_toggle_reset,
   input wire logic [ep_dma_pkg::EP_SLOTS-1:0] o_ep_enable,
   input wire logic [1:0] o_transactions_per_microframe
);
   logic cmd_seen_q;
   // A command write has been taken since reset
   wire cmd_take = i_cyc && i_stb && i_we && !o_ack && i_adr == ADDR_DMA_CMD;
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cmd_seen_q <= 1'b0;
      end else if (cmd_take) begin
         cmd_seen_q <= 1'b1;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence wb_take;
      i_cyc && i_stb && !o_ack;
   endsequence
   ack_timing_a: assert property (wb_take |=> o_ack) else $error("ack missing");
   ack_single_a: assert property (o_ack |=> !o_ack) else $error("ack too long");
   unmapped_zero_a: assert property (o_ack && i_adr == 8'hF0 |-> o_dat == 32'h0) else $error("unmapped data");
   bus_release_a: assert property (!cmd_seen_q |-> !o_dma_bus.data_oe) else $error("bus driven early");
   toggle_en_a: assert property (|o_toggle_reset |-> (o_toggle_reset & ~o_ep_enable) == '0)
      else $error("toggle on disabled slot");
   transactions_per_microframe_legal_a: assert property (o_transactions_per_microframe != TRANSACTIONS_PER_MICROFRAME_RESERVED) else $error("transactions_per_microframe");
   validate_cause_a: assert property (o_validate |-> $past(i_pio_byte_wr)) else $error("stray validate");
   empty_cause_a: assert property (o_send_empty |-> $past(i_usb.in_token)) else $error("stray empty");
endmodule

bind ep_buffer_dma_ctrl ep_dma_props props (.i_core_clk, .i_rst, .i_cyc, .i_stb, .i_we, .i_adr, .o_dat, .o_ack,
   .i_usb, .i_pio_byte_wr, .o_dma_bus, .o_validate, .o_send_empty, .o_toggle_reset, .o_ep_enable,
   .o_transactions_per_microframe);

// ### verif/tb.sv
// Testbench for the endpoint buffer and DMA control block
`timescale 1ns/1ps
module tb;
   import ep_dma_pkg::*;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_bus_reset = 1'b0;
   logic i_cyc = 1'b0;
   logic i_stb = 1'b0;
   logic i_we = 1'b0;
   logic [7:0] i_adr = 8'h00;
   logic [3:0] i_sel = 4'h0;
   logic [31:0] i_dat = 32'h0;
   usb_evt_t i_usb = '0;
   logic i_pio_byte_wr = 1'b0;
   logic go = 1'b0;
   logic end_req = 1'b0;
   logic tog_seen = 1'b0;
   logic empty_seen = 1'b0;
   logic val_seen = 1'b0;
   logic bus16 = 1'b0;
   logic odd_low;
   logic [SLOT_W-1:0] vslot;
   logic end_of_transfer_in, rdy, strb, dreq, o_ack, o_validate, o_send_empty, o_dma_irq;
   logic [15:0] far_data;
   logic [31:0] o_dat, q;
   dma_ctl_t o_dma_ctl;
   dma_bus_t o_dma_bus;
   logic [EP_SLOTS-1:0] o_toggle_reset, o_ep_enable, o_dbl_buf;
   logic [1:0] o_transactions_per_microframe;
   int mismatches = 0;
   int n_compared = 0;
   row_t rows [6];
   ep_buffer_dma_ctrl DUT (.i_core_clk, .i_rst, .i_bus_reset, .i_cyc, .i_stb, .i_we, .i_adr, .i_sel, .i_dat,
      .o_dat, .o_ack, .i_usb, .i_pio_byte_wr, .i_bus16(bus16), .i_eot_pin(end_of_transfer_in), .i_ready_pin(rdy),
      .i_dreq_pin(dreq), .i_strb_pin(strb), .i_dma_data(far_data), .o_dma_ctl, .o_dma_bus, .o_validate,
      .o_validate_slot(vslot), .o_send_empty, .o_toggle_reset, .o_ep_enable, .o_dbl_buf,
      .o_transactions_per_microframe, .o_odd_lane_low(odd_low), .o_dma_irq);
   dma_far_model far (.i_core_clk, .i_go(go), .i_end(end_req), .o_strb(strb), .o_eot(end_of_transfer_in), .o_ready(rdy),
      .o_dreq(dreq), .o_data(far_data));
   // Clock
   initial begin
      forever #10 i_core_clk = ~i_core_clk;
   end
   // Catch one-cycle event pulses: toggle reset of slot 3, empty packet and validate
   always @(posedge i_core_clk) begin
      if (o_toggle_reset[3] === 1'b1) tog_seen = 1'b1;
      if (o_send_empty === 1'b1) empty_seen = 1'b1;
      if (o_validate === 1'b1) val_seen = 1'b1;
   end
   task automatic wrap_up();
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge i_core_clk);
      i_cyc <= 1'b1;
      i_stb <= 1'b1;
      i_we <= we;
      i_adr <= a;
      i_dat <= d;
      i_sel <= s;
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge i_core_clk);
      end while (o_ack !== 1'b1);
      q = o_dat;
      i_cyc <= 1'b0;
      i_stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      chk(nm, e, q);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   task automatic evt(input usb_evt_t v);
      i_usb <= v;
      @(posedge i_core_clk);
      i_usb <= '0;
      ticks(3);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (o_dma_irq !== 1'b1 && n < 3000) begin
         @(posedge i_core_clk);
         n++;
      end
      chk("irq", 32'h1, {31'h0, o_dma_irq});
   endtask
   task automatic stat_chk(input logic [31:0] e);
      rd("status", ADDR_DMA_STAT, e);
      wr(ADDR_DMA_STAT, 32'h7);
      rd("cleared", ADDR_DMA_STAT, 32'h0);
   endtask
   // Hang guard
   initial begin
      #1200000;
      mismatches++;
      wrap_up();
   end
   initial begin
      rows = '{'{ADDR_PKT_SIZE, 32'hE840, 32'h0840}, '{ADDR_EP_TYPE, 32'h09, 32'h09},
         '{ADDR_EP_TYPE, 32'h1B, 32'h1B}, '{ADDR_EP_TYPE, 32'h0E, 32'h0E}, '{ADDR_PKT_LEN, 32'h3E, 32'h3E},
         '{8'hF0, 32'hFFFFFFFF, 32'h0}};
      repeat (16) @(posedge i_core_clk);
      i_rst <= 1'b0;
      rd("size", ADDR_PKT_SIZE, 32'h0);
      rd("type", ADDR_EP_TYPE, 32'h0);
      rd("len", ADDR_PKT_LEN, 32'h0);
      chk("oe", 32'h0, {31'h0, o_dma_bus.data_oe});
      wr(ADDR_EP_INDEX, 32'h3);
      for (int i = 0; i < 6; i++) begin
         wr(rows[i].a, rows[i].d);
         rd("row", rows[i].a, rows[i].e);
      end
      chk("transactions_per_microframe", 32'h1, {30'h0, o_transactions_per_microframe});
      chk("enable", 32'h1, {31'h0, o_ep_enable[3]});
      chk("dbl", 32'h1, {31'h0, o_dbl_buf[3]});
      wr(ADDR_PKT_SIZE, 32'h1840);
      chk("transactions_per_microframe_rsv", 32'h0, {30'h0, o_transactions_per_microframe});
      wr(ADDR_PKT_SIZE, 32'h20);
      rd("reload", ADDR_PKT_LEN, 32'h20);
      wr(ADDR_EP_INDEX, 32'h4);
      rd("reload2", ADDR_PKT_LEN, 32'h20);
      evt('{1'b1, 16'h001D, 1'b0, 1'b0, 4'h4});
      rd("outlen", ADDR_PKT_LEN, 32'h1D);
      i_bus_reset <= 1'b1;
      ticks(2);
      i_bus_reset <= 1'b0;
      rd("busrst", ADDR_PKT_LEN, 32'h0);
      // Re-enable, empty packets and automatic validation on slot 3
      wr(ADDR_EP_INDEX, 32'h3);
      wr(ADDR_EP_TYPE, 32'h0);
      tog_seen = 1'b0;
      wr(ADDR_EP_TYPE, 32'h8);
      ticks(2);
      chk("toggle", 32'h1, {31'h0, tog_seen});
      // Empty packets only count while a DMA command runs
      wr(ADDR_DMA_CMD, {24'h0, CMD_GENERIC_SLAVE_TRANSFER_RD});
      chk("dreq_out", 32'h1, {31'h0, o_dma_ctl.dreq});
      evt('{1'b0, 16'h0, 1'b1, 1'b0, 4'h3});
      chk("empty", 32'h1, {31'h0, empty_seen});
      wr(ADDR_EP_TYPE, 32'h18);
      empty_seen = 1'b0;
      evt('{1'b0, 16'h0, 1'b1, 1'b0, 4'h3});
      chk("noempty", 32'h0, {31'h0, empty_seen});
      wr(ADDR_DMA_CMD, {24'h0, CMD_RESET_DMA});
      wr(ADDR_PKT_LEN, 32'h2);
      i_pio_byte_wr <= 1'b1;
      ticks(2);
      i_pio_byte_wr <= 1'b0;
      ticks(3);
      chk("valid", 32'h1, {31'h0, val_seen});
      chk("vslot", 32'h3, {28'h0, vslot});
      // Odd length on a 16-bit bus puts the last byte low
      wr(ADDR_PKT_LEN, 32'h3);
      bus16 <= 1'b1;
      ticks(1);
      chk("odd_low", 32'h1, {31'h0, odd_low});
      bus16 <= 1'b0;
      // Counted slave transfer, count loaded byte by byte
      wr(ADDR_DMA_CFG, 32'h0);
      wb(1'b1, ADDR_XFER_CNT, 32'h4, 4'h1);
      wb(1'b1, ADDR_XFER_CNT, 32'h4, 4'h2);
      wb(1'b1, ADDR_XFER_CNT, 32'h4, 4'h4);
      rd("cnt", ADDR_XFER_CNT, 32'h0);
      wb(1'b1, ADDR_XFER_CNT, 32'h4, 4'h8);
      rd("cnt", ADDR_XFER_CNT, 32'h4);
      wr(ADDR_DMA_CMD, {24'h0, CMD_GENERIC_SLAVE_TRANSFER_RD});
      go <= 1'b1;
      wait_irq();
      chk("oe_on", 32'h1, {31'h0, o_dma_bus.data_oe});
      go <= 1'b0;
      stat_chk(32'h1);
      wr(ADDR_XFER_CNT, 32'h64);
      wr(ADDR_DMA_CMD, {24'h0, CMD_GENERIC_SLAVE_TRANSFER_RD});
      go <= 1'b1;
      ticks(20);
      end_req <= 1'b1;
      ticks(4);
      end_req <= 1'b0;
      wait_irq();
      go <= 1'b0;
      stat_chk(32'h2);
      wr(ADDR_DMA_CFG, 32'h80);
      wr(ADDR_DMA_CMD, {24'h0, CMD_GENERIC_SLAVE_TRANSFER_WR});
      evt('{1'b0, 16'h0, 1'b0, 1'b1, 4'h2});
      wait_irq();
      stat_chk(32'h4);
      wr(ADDR_XFER_CNT, 32'h4);
      wr(ADDR_DMA_CFG, 32'hA080);
      wr(ADDR_DMA_CMD, {24'h0, CMD_MDMA_RD});
      go <= 1'b1;
      wait_irq();
      go <= 1'b0;
      stat_chk(32'h1);
      wrap_up();
   end
endmodule
